// ### design/gsic_pkg.sv
// Purpose: shared constants and types of the global sync and interrupt control block
// Assumes: one 250 MHz core clock, asynchronous active-high reset
// Notes: register indices are word indices on the internal register port
//
// Functional notes
// - pin hop-sync global enable bit 7 gates hop sync on pin-driven channels.
// - pin start-sync global enable bit 6 gates start sync on pin-driven channels.
// - first-only bit 5 accepts only the first sync event, ignores later ones.
// - edge bit 4 set means rising edge is event, clear means high level.
// - bits 3..0 enable sync pins; each channel picks one pin.
// - soft hop enable bit 7 applies hop sync to channels selected in 5..0.
// - soft start enable bit 6 applies start sync to selected channels.
// - writing soft select bits 5..0 fires the chosen sync on set channels.
// - bit 10 selects CMOS when set, LVDS when clear; resets to CMOS.
// - setting autocalibrate bit 8 runs calibration, result applied at end.
// - with autocalibrate clear the pads take manual value bits 3..0.
// - flags 15..10 set on enabled AGC RSSI update that differs from previous.
// - flags 9..4 set when a channel's signature registers are loaded.
// - flags 3..0 set when enabled port power-monitor period expires.
// - interrupt flags are read-only; host writes leave them unchanged.
// - mask bits 15..10 clear means no RSSI interrupt for that AGC.
// - mask bits 9..4 clear means no data-ready interrupt for that channel.
// - ports B and D only monitored in real CMOS mode.
// - start sync starts a channel only if its enable was set beforehand.
`default_nettype none

package gsic_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned CAL_SETTLE_NS = 40;
	localparam int unsigned CAL_SETTLE_CYC =
		(CAL_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 16;
	localparam logic [2:0] ADDR_PIN_SYNC = 3'h0;
	localparam logic [2:0] ADDR_SOFT_SYNC = 3'h1;
	localparam logic [2:0] ADDR_PAD_MODE = 3'h2;
	localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;

	// reset values
	localparam logic [7:0] PIN_SYNC_RST = 8'h00;
	localparam logic [7:0] SOFT_SYNC_RST = 8'h00;
	localparam logic [10:0] PAD_MODE_RST = 11'h600;
	localparam logic [15:0] IRQ_RST = 16'h0000;

	// field positions
	localparam int unsigned HOP_EN_BIT = 7;
	localparam int unsigned START_EN_BIT = 6;
	localparam int unsigned FIRST_ONLY_BIT = 5;
	localparam int unsigned EDGE_BIT = 4;
	localparam int unsigned CMOS_BIT = 10;
	localparam int unsigned AUTOCAL_BIT = 8;
	localparam int unsigned PAD_MODE_W = 11;
	localparam int unsigned RSSI_LSB = 10;
	localparam int unsigned BIST_LSB = 4;
	localparam int unsigned PM_LSB = 0;
	localparam int unsigned PORT_B = 1;
	localparam int unsigned PORT_D = 3;

	// sizes
	localparam int unsigned NUM_CH = 6;
	localparam int unsigned NUM_PIN = 4;
	localparam int unsigned NUM_PORT = 4;
	localparam int unsigned RSSI_W = 12;
	localparam int unsigned CAL_W = 4;
	localparam logic [3:0] CAL_MAX = 4'hF;

	// calibration engine states
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_SETTLE = 2'b01,
		CAL_DONE = 2'b10
	} gsic_cal_state_t;
endpackage
`default_nettype wire

// ### design/gsic_cal_if.sv
// Purpose: carrier between the control registers and the pad calibration engine
// Assumes: single clock domain
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface gsic_cal_if;
	logic start;
	logic cmp;
	logic busy;
	logic done;
	logic [3:0] code;

	modport ctrl (output start, output cmp, input busy, input done, input code);
	modport eng (input start, input cmp, output busy, output done, output code);
endinterface
`default_nettype wire

// ### design/gsic_cal_engine.sv
// Purpose: LVDS pad autocalibration sweep
// Assumes: pad comparator input is synchronous to clk
// Notes: steps codes upward, stops at first code where the comparator trips or at max
`timescale 1ns/1ps
`default_nettype none
module gsic_cal_engine (
	input wire logic clk, // core clock
	input wire logic reset, // async reset, active high
	gsic_cal_if.eng cal // calibration carrier
);
	gsic_pkg::gsic_cal_state_t state;
	logic [7:0] settle_cnt;
	logic settle_end;

	// end of one settle interval
	assign settle_end = (settle_cnt == 8'(gsic_pkg::CAL_SETTLE_CYC - 1));
	assign cal.busy = (state == gsic_pkg::CAL_SETTLE);
	assign cal.done = (state == gsic_pkg::CAL_DONE);

	// sweep state machine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= gsic_pkg::CAL_IDLE;
		end else if (cal.start) begin
			state <= gsic_pkg::CAL_SETTLE;
		end else begin
			unique case (state)
				gsic_pkg::CAL_IDLE: begin
					state <= gsic_pkg::CAL_IDLE;
				end
				gsic_pkg::CAL_SETTLE: begin
					if (settle_end && (cal.cmp || cal.code == gsic_pkg::CAL_MAX)) begin
						state <= gsic_pkg::CAL_DONE;
					end
				end
				gsic_pkg::CAL_DONE: begin
					state <= gsic_pkg::CAL_DONE;
				end
				default: begin
					state <= gsic_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	// settle counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			settle_cnt <= 8'h00;
		end else if (cal.start || settle_end || state != gsic_pkg::CAL_SETTLE) begin
			settle_cnt <= 8'h00;
		end else begin
			settle_cnt <= settle_cnt + 8'h01;
		end
	end

	// code under trial
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cal.code <= 4'h0;
		end else if (cal.start) begin
			cal.code <= 4'h0;
		end else if (state == gsic_pkg::CAL_SETTLE && settle_end && !cal.cmp
			&& cal.code != gsic_pkg::CAL_MAX) begin
			cal.code <= cal.code + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### design/gsic_top.sv
// Purpose: global sync triggering, input pad mode and interrupt flag control
// Assumes: register port and event inputs synchronous to clk
// Notes: read data answers one cycle after rd_en; flag reads clear the flags read
`timescale 1ns/1ps
`default_nettype none
module gsic_top (
	input wire logic clk, // core clock, 250 MHz
	input wire logic reset, // async reset, active high
	input wire logic [2:0] reg_addr, // register index
	input wire logic wr_en, // write strobe
	input wire logic [15:0] wr_data, // write data
	input wire logic rd_en, // read strobe
	output logic [15:0] rd_data, // read data, valid cycle after rd_en
	input wire logic [3:0] sync_pin, // external sync pins
	input wire logic [5:0] chan_pin_mode, // channel programmed for pin sync
	input wire logic [11:0] chan_pin_sel, // 2-bit pin choice per channel
	input wire logic [5:0] chan_enable, // channel enable bits
	output logic [5:0] hop_sync, // per-channel hop sync pulse
	output logic [5:0] start_sync, // per-channel start sync pulse
	output logic cmos_mode, // 1 CMOS ports, 0 LVDS ports
	output logic [3:0] lvds_cal, // calibration value to pads
	input wire logic pad_cmp, // pad calibration comparator
	output logic cal_busy, // autocalibration running
	input wire logic [5:0] rssi_valid, // AGC produced an RSSI word
	input wire logic [71:0] rssi_word, // 12-bit RSSI word per AGC
	input wire logic [5:0] bist_loaded, // signature registers loaded
	input wire logic [3:0] pm_expire, // power-monitor period ended
	input wire logic port_a_complex, // ports A/B form a complex pair
	input wire logic port_c_complex, // ports C/D form a complex pair
	output logic irq // any flag set
);
	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0] pin_sync_config;
	logic [7:0] soft_sync_config;
	logic [10:0] input_pad_mode_control;
	logic [15:0] interrupt_flags;
	logic [15:0] interrupt_mask;
	logic [3:0] sync_pin_d;
	logic [3:0] pin_event;
	logic [5:0] sync_seen;
	logic [5:0] next_hop;
	logic [5:0] next_start;
	logic [71:0] rssi_prev;
	logic [5:0] rssi_changed;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [3:0] auto_value;
	logic [3:0] port_active;
	logic soft_write;
	logic first_only;
	gsic_cal_if cal_bus ();

	// address match on a strobe
	function automatic logic hit(input logic en, input logic [2:0] a, input logic [2:0] b);
		hit = en && (a == b);
	endfunction

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	assign soft_write = hit(wr_en, reg_addr, gsic_pkg::ADDR_SOFT_SYNC);
	assign first_only = pin_sync_config[gsic_pkg::FIRST_ONLY_BIT];

	// pin sync configuration
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_sync_config <= gsic_pkg::PIN_SYNC_RST;
		end else if (hit(wr_en, reg_addr, gsic_pkg::ADDR_PIN_SYNC)) begin
			pin_sync_config <= wr_data[7:0];
		end
	end

	// soft sync configuration
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			soft_sync_config <= gsic_pkg::SOFT_SYNC_RST;
		end else if (soft_write) begin
			soft_sync_config <= wr_data[7:0];
		end
	end

	// pad mode; bit 9 stored as the host writes it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			input_pad_mode_control <= gsic_pkg::PAD_MODE_RST;
		end else if (hit(wr_en, reg_addr, gsic_pkg::ADDR_PAD_MODE)) begin
			input_pad_mode_control <= wr_data[10:0];
		end
	end

	// interrupt mask
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interrupt_mask <= gsic_pkg::IRQ_RST;
		end else if (hit(wr_en, reg_addr, gsic_pkg::ADDR_IRQ_MASK)) begin
			interrupt_mask <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// sync triggering
	// ----------------------------------------------------------------
	// pin history for edge detection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_pin_d <= 4'h0;
		end else begin
			sync_pin_d <= sync_pin;
		end
	end

	// per-pin event: edge or level, gated by pin enable
	always_comb begin
		if (pin_sync_config[gsic_pkg::EDGE_BIT]) begin
			pin_event = sync_pin & ~sync_pin_d;
		end else begin
			pin_event = sync_pin;
		end
		pin_event = pin_event & pin_sync_config[3:0];
	end

	// combine pin and soft requests per channel
	always_comb begin
		next_hop = 6'h00;
		next_start = 6'h00;
		for (int ch = 0; ch < gsic_pkg::NUM_CH; ch++) begin
			// channel listens to a single pin of its choice
			if (chan_pin_mode[ch] && pin_event[chan_pin_sel[2*ch +: 2]]) begin
				next_hop[ch] = pin_sync_config[gsic_pkg::HOP_EN_BIT];
				next_start[ch] = pin_sync_config[gsic_pkg::START_EN_BIT];
			end
			// soft sync fires on the write of the select bits
			if (soft_write && wr_data[ch]) begin
				next_hop[ch] = next_hop[ch] | wr_data[gsic_pkg::HOP_EN_BIT];
				next_start[ch] = next_start[ch] | wr_data[gsic_pkg::START_EN_BIT];
			end
			next_start[ch] = next_start[ch] & chan_enable[ch];
			// later events dropped while first-only holds
			if (first_only && sync_seen[ch]) begin
				next_hop[ch] = 1'b0;
				next_start[ch] = 1'b0;
			end
		end
	end

	// first event memory, released when first-only is cleared
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_seen <= 6'h00;
		end else if (!first_only) begin
			sync_seen <= 6'h00;
		end else begin
			sync_seen <= sync_seen | (next_hop | next_start);
		end
	end

	// sync pulses to the channels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hop_sync <= 6'h00;
			start_sync <= 6'h00;
		end else begin
			hop_sync <= next_hop;
			start_sync <= next_start;
		end
	end

	// ----------------------------------------------------------------
	// pad mode and calibration
	// ----------------------------------------------------------------
	assign cal_bus.cmp = pad_cmp;
	assign cal_bus.start = hit(wr_en, reg_addr, gsic_pkg::ADDR_PAD_MODE)
		&& wr_data[gsic_pkg::AUTOCAL_BIT];
	assign cal_busy = cal_bus.busy;
	gsic_cal_engine u_cal (
		.clk(clk),
		.reset(reset),
		.cal(cal_bus.eng)
	);
	// calibration result taken at the end of the sweep
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			auto_value <= 4'h0;
		end else if (cal_bus.done) begin
			auto_value <= cal_bus.code;
		end
	end

	// pad outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmos_mode <= gsic_pkg::PAD_MODE_RST[gsic_pkg::CMOS_BIT];
			lvds_cal <= 4'h0;
		end else begin
			cmos_mode <= input_pad_mode_control[gsic_pkg::CMOS_BIT];
			if (input_pad_mode_control[gsic_pkg::AUTOCAL_BIT]) begin
				lvds_cal <= auto_value;
			end else begin
				lvds_cal <= input_pad_mode_control[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags
	// ----------------------------------------------------------------
	// previous RSSI words
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rssi_prev <= 72'h0;
		end else begin
			for (int a = 0; a < gsic_pkg::NUM_CH; a++) begin
				if (rssi_valid[a]) begin
					rssi_prev[12*a +: 12] <= rssi_word[12*a +: 12];
				end
			end
		end
	end
	// ports B and D exist only in real CMOS mode
	always_comb begin
		port_active = 4'hF;
		port_active[gsic_pkg::PORT_B] = cmos_mode && !port_a_complex;
		port_active[gsic_pkg::PORT_D] = cmos_mode && !port_c_complex;
		for (int a = 0; a < gsic_pkg::NUM_CH; a++) begin
			rssi_changed[a] = rssi_valid[a]
				&& (rssi_word[12*a +: 12] != rssi_prev[12*a +: 12]);
		end
	end

	// set and clear terms; clear on read of the flags
	assign flag_set = {rssi_changed, bist_loaded, pm_expire & port_active}
		& interrupt_mask;
	assign flag_clr = hit(rd_en, reg_addr, gsic_pkg::ADDR_IRQ_FLAGS) ? interrupt_flags : 16'h0000;
	// sticky flags, set wins; host writes never reach them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interrupt_flags <= gsic_pkg::IRQ_RST;
		end else begin
			interrupt_flags <= (interrupt_flags & ~flag_clr) | flag_set;
		end
	end
	assign irq = |interrupt_flags;

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			unique case (reg_addr)
				gsic_pkg::ADDR_PIN_SYNC: rd_data <= {8'h00, pin_sync_config};
				gsic_pkg::ADDR_SOFT_SYNC: rd_data <= {8'h00, soft_sync_config};
				gsic_pkg::ADDR_PAD_MODE: rd_data <= {5'h00, input_pad_mode_control};
				gsic_pkg::ADDR_IRQ_FLAGS: rd_data <= interrupt_flags;
				gsic_pkg::ADDR_IRQ_MASK: rd_data <= interrupt_mask;
				default: rd_data <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_autocal_write;
		wr_en && reg_addr == gsic_pkg::ADDR_PAD_MODE && wr_data[gsic_pkg::AUTOCAL_BIT];
	endsequence
	sequence s_sweep_runs;
		##1 cal_busy;
	endsequence
	property p_pin_hop_off;
		!pin_sync_config[gsic_pkg::HOP_EN_BIT] && !soft_write |=> hop_sync == 6'h00;
	endproperty
	a_pin_hop_off: assert property (p_pin_hop_off) else $error("hop sync while disabled");
	property p_pin_start_off;
		!pin_sync_config[gsic_pkg::START_EN_BIT] && !soft_write |=> start_sync == 6'h00;
	endproperty
	a_pin_start_off: assert property (p_pin_start_off) else $error("start sync while disabled");
	property p_first_only;
		first_only && sync_seen[0] |=> !hop_sync[0] && !start_sync[0];
	endproperty
	a_first_only: assert property (p_first_only) else $error("second sync accepted");
	property p_edge_held;
		pin_sync_config[gsic_pkg::EDGE_BIT] && sync_pin_d[0] |-> !pin_event[0];
	endproperty
	a_edge_held: assert property (p_edge_held) else $error("held pin seen as edge");
	property p_pin_disabled;
		!pin_sync_config[0] |-> !pin_event[0];
	endproperty
	a_pin_disabled: assert property (p_pin_disabled) else $error("disabled pin fired");
	property p_soft_start;
		soft_write && wr_data[0] && wr_data[gsic_pkg::START_EN_BIT] && chan_enable[0]
			&& !(first_only && sync_seen[0]) |=> start_sync[0];
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("soft start missing");
	property p_start_needs_enable;
		!chan_enable[0] |=> !start_sync[0];
	endproperty
	a_start_needs_enable: assert property (p_start_needs_enable) else $error("start on disabled");
	property p_lvds_select;
		wr_en && reg_addr == gsic_pkg::ADDR_PAD_MODE && !wr_data[gsic_pkg::CMOS_BIT]
			|-> ##2 !cmos_mode;
	endproperty
	a_lvds_select: assert property (p_lvds_select) else $error("LVDS mode not taken");
	property p_autocal_runs;
		s_autocal_write |-> s_sweep_runs;
	endproperty
	a_autocal_runs: assert property (p_autocal_runs) else $error("calibration not started");
	property p_manual_cal;
		!input_pad_mode_control[gsic_pkg::AUTOCAL_BIT] |=>
			lvds_cal == $past(input_pad_mode_control[3:0]);
	endproperty
	a_manual_cal: assert property (p_manual_cal) else $error("manual value not applied");
	property p_rssi_masked;
		!interrupt_mask[10] && !interrupt_flags[10] |=> !interrupt_flags[10];
	endproperty
	a_rssi_masked: assert property (p_rssi_masked) else $error("masked RSSI flag set");
	property p_bist_flag;
		bist_loaded[0] && interrupt_mask[4] |=> interrupt_flags[4];
	endproperty
	a_bist_flag: assert property (p_bist_flag) else $error("data-ready flag missed");
	property p_flags_ro;
		wr_en && reg_addr == gsic_pkg::ADDR_IRQ_FLAGS && flag_set == 16'h0000 && !rd_en
			|=> $stable(interrupt_flags);
	endproperty
	a_flags_ro: assert property (p_flags_ro) else $error("flags changed by write");
	property p_port_b_idle;
		!port_active[gsic_pkg::PORT_B] && !interrupt_flags[1] |=> !interrupt_flags[1];
	endproperty
	a_port_b_idle: assert property (p_port_b_idle) else $error("inactive port B flagged");
endmodule
`default_nettype wire

// ### testbench/gsic_host.sv
// Purpose: host processor model on the register port
// Assumes: each request launches 1 ns after the next rising edge
// Notes: pad mode writes always carry the reserved bit
`timescale 1ns/1ps
`default_nettype none
module gsic_host (
	input wire logic clk, // core clock
	output logic [2:0] reg_addr, // register index
	output logic wr_en, // write strobe
	output logic [15:0] wr_data, // write data
	output logic rd_en, // read strobe
	input wire logic [15:0] rd_data // read data
);
	// idle bus
	initial begin
		reg_addr = 3'h0;
		wr_en = 1'b0;
		wr_data = 16'h0000;
		rd_en = 1'b0;
	end
	// one write; data scrambled after release so stale data never passes
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		wr_data = (a == gsic_pkg::ADDR_PAD_MODE) ? (v | 16'h0200) : v;
		wr_en = 1'b1;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		wr_data = ~wr_data;
	endtask
	// one read; data taken once the answer edge has landed
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk);
		#1;
		reg_addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		v = rd_data;
	endtask
endmodule
`default_nettype wire

// ### testbench/gsic_tb_top.sv
// Purpose: self-checking bench for the sync, pad mode and flag block
// Assumes: inputs change 1 ns after the rising edge
// Notes: random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module gsic_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] reg_addr;
	logic wr_en;
	logic [15:0] wr_data;
	logic rd_en;
	logic [15:0] rd_data;
	logic [3:0] sync_pin = 4'h0;
	logic [5:0] chan_pin_mode = 6'h00;
	logic [11:0] chan_pin_sel = 12'h000;
	logic [5:0] chan_enable = 6'h00;
	logic [5:0] hop_sync;
	logic [5:0] start_sync;
	logic cmos_mode;
	logic [3:0] lvds_cal;
	logic pad_cmp = 1'b0;
	logic cal_busy;
	logic [5:0] rssi_valid = 6'h00;
	logic [71:0] rssi_word = 72'h0;
	logic [5:0] bist_loaded = 6'h00;
	logic [3:0] pm_expire = 4'h0;
	logic port_a_complex = 1'b0;
	logic port_c_complex = 1'b0;
	logic irq;
	int err_total = 0;
	int compares = 0;
	logic [15:0] d;
	logic [15:0] m;
	logic [15:0] e;
	logic [11:0] prev [6] = '{default: 12'h000};
	logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h0600, 16'h0000, 16'h0000, 16'h0000};
	// clock
	always #2 clk = ~clk;
	gsic_host h (.clk(clk), .reg_addr(reg_addr), .wr_en(wr_en), .wr_data(wr_data),
		.rd_en(rd_en), .rd_data(rd_data));
	gsic_top DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .sync_pin(sync_pin),
		.chan_pin_mode(chan_pin_mode), .chan_pin_sel(chan_pin_sel), .chan_enable(chan_enable),
		.hop_sync(hop_sync), .start_sync(start_sync), .cmos_mode(cmos_mode),
		.lvds_cal(lvds_cal), .pad_cmp(pad_cmp), .cal_busy(cal_busy), .rssi_valid(rssi_valid),
		.rssi_word(rssi_word), .bist_loaded(bist_loaded), .pm_expire(pm_expire),
		.port_a_complex(port_a_complex), .port_c_complex(port_c_complex), .irq(irq));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("err_total %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// pin sync per channel through pin enable and global gate
	function automatic logic [5:0] pin_exp(input logic [7:0] c, input logic [3:0] ev, input logic g);
		logic [5:0] r;
		for (int k = 0; k < 6; k++) begin
			r[k] = g & chan_pin_mode[k] & c[chan_pin_sel[2*k+:2]] & ev[chan_pin_sel[2*k+:2]];
		end
		return r;
	endfunction
	// flags raised by the events now on the inputs
	function automatic logic [15:0] flag_exp(input logic [15:0] mk, input logic cm);
		logic [15:0] f;
		for (int k = 0; k < 6; k++) begin
			f[10+k] = rssi_valid[k] & (rssi_word[12*k+:12] != prev[k]);
		end
		f[9:4] = bist_loaded;
		f[3:0] = pm_expire & {cm & ~port_c_complex, 1'b1, cm & ~port_a_complex, 1'b1};
		return f & mk;
	endfunction
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hcc1a));
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		// reset values, unmapped index reads zero
		for (int i = 0; i < 6; i++) begin
			h.rd(i[2:0], d);
			chk(d, rst[i], "reset value");
		end
		chk(16'(cmos_mode), 16'h0001, "cmos after reset");
		h.wr(gsic_pkg::ADDR_IRQ_FLAGS, 16'hffff);
		h.rd(gsic_pkg::ADDR_IRQ_FLAGS, d);
		chk(d, 16'h0000, "flags written");
		// software sync
		for (int i = 0; i < 20; i++) begin
			m = 16'($urandom()) & 16'h00ff;
			chan_enable = 6'($urandom());
			h.wr(gsic_pkg::ADDR_SOFT_SYNC, m);
			chk(16'({hop_sync, start_sync}), 16'({m[7] ? m[5:0] : 6'h00,
				m[6] ? m[5:0] & chan_enable : 6'h00}), "soft sync");
		end
		// pin sync, first cycle then held level
		chan_enable = 6'h3f;
		for (int i = 0; i < 20; i++) begin
			m = 16'($urandom()) & 16'h00df;
			chan_pin_mode = 6'($urandom());
			chan_pin_sel = 12'($urandom());
			h.wr(gsic_pkg::ADDR_PIN_SYNC, m);
			sync_pin = 4'($urandom());
			tick();
			e = 16'({pin_exp(m[7:0], sync_pin, m[7]), pin_exp(m[7:0], sync_pin, m[6])});
			chk(16'({hop_sync, start_sync}), e, "pin sync");
			tick();
			chk(16'({hop_sync, start_sync}), m[4] ? 16'h0000 : e, "pin held");
			sync_pin = 4'h0;
			tick();
		end
		// first-only accepts one event per channel
		h.wr(gsic_pkg::ADDR_PIN_SYNC, 16'h0020);
		h.wr(gsic_pkg::ADDR_SOFT_SYNC, 16'h0081);
		chk(16'(hop_sync), 16'h0001, "first event");
		h.wr(gsic_pkg::ADDR_SOFT_SYNC, 16'h0081);
		chk(16'(hop_sync), 16'h0000, "later event");
		h.wr(gsic_pkg::ADDR_PIN_SYNC, 16'h0000);
		h.wr(gsic_pkg::ADDR_SOFT_SYNC, 16'h0081);
		chk(16'(hop_sync), 16'h0001, "first-only off");
		// manual calibration in lvds mode
		m = 16'($urandom()) & 16'h000f;
		h.wr(gsic_pkg::ADDR_PAD_MODE, m);
		tick();
		chk(16'({cmos_mode, lvds_cal}), 16'({1'b0, m[3:0]}), "manual pad");
		// autocal trips at end of code 3, manual bits ignored
		h.wr(gsic_pkg::ADDR_PAD_MODE, 16'h0709);
		chk(16'(cal_busy), 16'h0001, "cal running");
		for (int k = 0; cal_busy === 1'b1; k++) begin
			pad_cmp = (k >= 32);
			tick();
			if (k > 300) begin
				err_total++;
				end_sim();
			end
		end
		repeat (3) tick();
		chk(16'(lvds_cal), 16'h0003, "autocal result");
		pad_cmp = 1'b0;
		// random events against mask and port mode
		for (int i = 0; i < 40; i++) begin
			m = 16'($urandom());
			h.wr(gsic_pkg::ADDR_IRQ_MASK, m);
			d = 16'($urandom()) & 16'h0400;
			h.wr(gsic_pkg::ADDR_PAD_MODE, d);
			tick();
			port_a_complex = 1'($urandom());
			port_c_complex = 1'($urandom());
			rssi_valid = 6'($urandom());
			rssi_word = 72'({$urandom(), $urandom(), $urandom()});
			if (i % 4 == 0) begin
				rssi_word = {prev[5], prev[4], prev[3], prev[2], prev[1], prev[0]};
			end
			bist_loaded = 6'($urandom());
			pm_expire = 4'($urandom());
			e = flag_exp(m, d[10]);
			for (int k = 0; k < 6; k++) begin
				if (rssi_valid[k]) begin
					prev[k] = rssi_word[12*k+:12];
				end
			end
			tick();
			rssi_valid = 6'h00;
			bist_loaded = 6'h00;
			pm_expire = 4'h0;
			chk(16'(irq), 16'(|e), "irq");
			h.rd(gsic_pkg::ADDR_IRQ_FLAGS, d);
			chk(d, e, "flags");
		end
		end_sim();
	end
endmodule
`default_nettype wire
